/* File: core/bbfh_cfg.svh */
// Purpose: Constants for the boot-block flash host controller
// Assumes: 100 MHz ref_clk, flash pins driven through level buffers
// Notes:   Supply and unlock levels are logic enables to external switches
`ifndef BBFH_CFG_SVH
`define BBFH_CFG_SVH
`define BBFH_CMD_ERASE_SETUP 8'h20
`define BBFH_CMD_WRITE_SETUP 8'h40
`define BBFH_CMD_ERASE_CONF  8'hd0
`define BBFH_CMD_READ_ARRAY  8'hff
`define BBFH_CLK_NS          10
`define BBFH_SETUP_NS        120
`define BBFH_PHASE_CYC       ((`BBFH_SETUP_NS + `BBFH_CLK_NS - 1) / `BBFH_CLK_NS)
`define BBFH_CNT_W           4
`define BBFH_RST_HOLD_NS     100
`define BBFH_RST_CYC         ((`BBFH_RST_HOLD_NS + `BBFH_CLK_NS - 1) / `BBFH_CLK_NS)
`endif

/* File: core/bbfh_pkg.sv */
// Purpose: Types for the boot-block flash host controller
// Assumes: Used with bbfh_cfg.svh
// Notes:   None
package bbfh_pkg;
	typedef enum logic [2:0] {
		BBFH_OP_READ   = 3'b000,
		BBFH_OP_ERASE  = 3'b001,
		BBFH_OP_WRITE  = 3'b010,
		BBFH_OP_ARRAY  = 3'b011,
		BBFH_OP_IDENT  = 3'b100,
		BBFH_OP_RESET  = 3'b101
	} bbfh_op_t;
	typedef enum logic [2:0] {
		BBFH_IDLE   = 3'b000,
		BBFH_SETUP  = 3'b001,
		BBFH_ASSERT = 3'b010,
		BBFH_RELEASE = 3'b011,
		BBFH_GAP    = 3'b100,
		BBFH_PRST   = 3'b101
	} bbfh_state_t;
endpackage

/* File: core/bbfh_host.sv */
// Purpose: Host-side bus controller driving a boot-block flash
// Assumes: One request at a time; device pins synchronous to ref_clk
// Notes:   Supply and unlock outputs switch external 12 V circuits
`timescale 1ns/1ps
`include "bbfh_cfg.svh"
module bbfh_host
	import bbfh_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        req_valid,
	input  wire bbfh_op_t    req_op,
	input  wire logic [18:0] req_addr,
	input  wire logic [15:0] req_wdata,
	input  wire logic        req_byte,
	input  wire logic        req_boot,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic [15:0]      rsp_rdata,
	output logic             chip_sel_n,
	output logic             out_en_n,
	output logic             wr_strobe_n,
	output logic             width_word,
	output logic             reset_n,
	output logic             boot_unlock_en,
	output logic             program_supply_en,
	output logic             identify_en,
	output logic [17:0]      address_inputs,
	input  wire logic [15:0] dq_in,
	output logic [15:0]      dq_out,
	output logic [15:0]      dq_oe_n
);
	bbfh_state_t            state_ff;
	bbfh_op_t               op_ff;
	logic [`BBFH_CNT_W-1:0] cnt_ff;
	logic                   second_ff;
	logic                   byte_ff;
	logic                   boot_ff;
	logic [18:0]            addr_ff;
	logic [15:0]            wdata_ff;
	logic                   two_cycle;
	logic                   is_read;
	logic                   phase_done;
	logic [7:0]             first_cmd;
	logic                   change_cyc;

	assign two_cycle  = (op_ff == BBFH_OP_ERASE) || (op_ff == BBFH_OP_WRITE);
	assign is_read    = (op_ff == BBFH_OP_READ) || (op_ff == BBFH_OP_IDENT);
	assign phase_done = (cnt_ff == `BBFH_CNT_W'(`BBFH_PHASE_CYC - 1));
	assign change_cyc = two_cycle && second_ff;
	always_comb begin
		unique case (op_ff)
			BBFH_OP_ERASE: first_cmd = `BBFH_CMD_ERASE_SETUP;
			BBFH_OP_WRITE: first_cmd = `BBFH_CMD_WRITE_SETUP;
			default:       first_cmd = `BBFH_CMD_READ_ARRAY;
		endcase
	end

	// Sequencer; setup, assert and release phases last the same count for simplicity
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff  <= BBFH_IDLE;
			cnt_ff    <= '0;
			second_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				BBFH_IDLE: begin
					cnt_ff    <= '0;
					second_ff <= 1'b0;
					if (req_valid)
						state_ff <= (req_op == BBFH_OP_RESET) ? BBFH_PRST : BBFH_SETUP;
				end
				BBFH_SETUP, BBFH_ASSERT: begin
					cnt_ff <= phase_done ? '0 : cnt_ff + 1'b1;
					if (phase_done)
						state_ff <= (state_ff == BBFH_SETUP) ? BBFH_ASSERT : BBFH_RELEASE;
				end
				BBFH_RELEASE: begin
					cnt_ff <= phase_done ? '0 : cnt_ff + 1'b1;
					if (phase_done)
						state_ff <= BBFH_GAP;
				end
				BBFH_GAP: begin
					// Erase or write setup is followed at once by its confirm or data cycle
					if (two_cycle && !second_ff) begin
						second_ff <= 1'b1;
						state_ff  <= BBFH_SETUP;
					end else begin
						state_ff <= BBFH_IDLE;
					end
				end
				BBFH_PRST: begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == `BBFH_CNT_W'(`BBFH_RST_CYC - 1))
						state_ff <= BBFH_IDLE;
				end
				default: state_ff <= BBFH_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_ff    <= BBFH_OP_READ;
			addr_ff  <= '0;
			wdata_ff <= '0;
			byte_ff  <= 1'b0;
			boot_ff  <= 1'b0;
		end else if (state_ff == BBFH_IDLE && req_valid) begin
			op_ff    <= req_op;
			addr_ff  <= req_addr;
			wdata_ff <= req_wdata;
			byte_ff  <= req_byte;
			boot_ff  <= req_boot;
		end
	end

	// Control strobes
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chip_sel_n  <= 1'b1;
			out_en_n    <= 1'b1;
			wr_strobe_n <= 1'b1;
			reset_n     <= 1'b0;
		end else begin
			reset_n    <= !(state_ff == BBFH_PRST);
			chip_sel_n <= !(state_ff == BBFH_SETUP || state_ff == BBFH_ASSERT);
			out_en_n   <= !(is_read && state_ff == BBFH_ASSERT);
			// Strobe rises a cycle ahead of select, so data still stands
			wr_strobe_n <= !(!is_read && state_ff == BBFH_ASSERT && !phase_done);
		end
	end

	// Supply and unlock levels bracket only the change cycle
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			program_supply_en <= 1'b0;
			boot_unlock_en    <= 1'b0;
			identify_en       <= 1'b0;
		end else begin
			program_supply_en <= change_cyc && state_ff != BBFH_IDLE;
			boot_unlock_en    <= change_cyc && boot_ff && state_ff != BBFH_IDLE;
			identify_en       <= (op_ff == BBFH_OP_IDENT) && state_ff != BBFH_IDLE &&
				state_ff != BBFH_PRST;
		end
	end

	// Address and data pins
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			address_inputs <= '0;
			width_word     <= 1'b1;
			dq_out         <= '0;
			dq_oe_n        <= '1;
		end else begin
			width_word <= !byte_ff;
			if (op_ff == BBFH_OP_IDENT)
				address_inputs <= {17'h00000, addr_ff[0]};
			else
				address_inputs <= byte_ff ? addr_ff[18:1] : addr_ff[17:0];
			dq_oe_n <= '1;
			dq_out  <= '0;
			if (state_ff == BBFH_SETUP || state_ff == BBFH_ASSERT) begin
				if (!is_read && (!two_cycle || !second_ff)) begin
					dq_out  <= {8'h00, first_cmd};
					dq_oe_n <= 16'hff00;
				end else if (change_cyc && op_ff == BBFH_OP_WRITE) begin
					dq_out  <= byte_ff ? {addr_ff[0], 7'h00, wdata_ff[7:0]} : wdata_ff;
					dq_oe_n <= byte_ff ? 16'h7f00 : 16'h0000;
				end else if (change_cyc) begin
					dq_out  <= {8'h00, `BBFH_CMD_ERASE_CONF};
					dq_oe_n <= 16'hff00;
				end else if (is_read && byte_ff && op_ff == BBFH_OP_READ) begin
					dq_out  <= {addr_ff[0], 15'h0000};
					dq_oe_n <= 16'h7fff;
				end
			end
		end
	end

	// Answer
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state_ff == BBFH_IDLE) && !req_valid;
			// Pin reset ends with an answer too, or the requester would hang
			rsp_valid <= ((state_ff == BBFH_GAP) && !(two_cycle && !second_ff)) ||
				(state_ff == BBFH_PRST && cnt_ff == `BBFH_CNT_W'(`BBFH_RST_CYC - 1));
			if (is_read && state_ff == BBFH_ASSERT && phase_done)
				rsp_rdata <= byte_ff ? {8'h00, dq_in[7:0]} : dq_in;
		end
	end

	property p_strobe_excl;
		@(posedge ref_clk) disable iff (sys_rst) !(out_en_n == 1'b0 && wr_strobe_n == 1'b0);
	endproperty
	a_strobe_excl: assert property (p_strobe_excl) else $error("oe and we low together");
	property p_sel_float;
		@(posedge ref_clk) disable iff (sys_rst) chip_sel_n |-> (dq_oe_n == 16'hffff);
	endproperty
	a_sel_float: assert property (p_sel_float) else $error("pins driven while deselected");
	property p_read_float;
		@(posedge ref_clk) disable iff (sys_rst) !out_en_n |-> dq_oe_n[14:0] == 15'h7fff;
	endproperty
	a_read_float: assert property (p_read_float) else $error("host drives during read");
	property p_byte_hi;
		@(posedge ref_clk) disable iff (sys_rst) !width_word |-> dq_oe_n[14:8] == 7'h7f;
	endproperty
	a_byte_hi: assert property (p_byte_hi) else $error("upper pins driven in byte mode");
	property p_unlock_supply;
		@(posedge ref_clk) disable iff (sys_rst) boot_unlock_en |-> program_supply_en;
	endproperty
	a_unlock_supply: assert property (p_unlock_supply) else $error("unlock without supply");
	property p_supply_write;
		@(posedge ref_clk) disable iff (sys_rst) $rose(program_supply_en) |-> wr_strobe_n;
	endproperty
	a_supply_write: assert property (p_supply_write) else $error("supply rose mid strobe");
	sequence s_strobe_end;
		$rose(wr_strobe_n);
	endsequence
	sequence s_sel_release;
		!chip_sel_n ##1 chip_sel_n;
	endsequence
	property p_latch_order;
		@(posedge ref_clk) disable iff (sys_rst) s_strobe_end |-> s_sel_release;
	endproperty
	a_latch_order: assert property (p_latch_order) else $error("select not released after strobe");
	property p_reset_level;
		@(posedge ref_clk) disable iff (sys_rst) !reset_n |-> chip_sel_n;
	endproperty
	a_reset_level: assert property (p_reset_level) else $error("select during reset");
endmodule

/* File: sim/bbfh_flash_model.sv */
// Purpose: Behavioural boot-block flash device facing the host controller
// Assumes: Top boot variant; writes and erases finish at once
// Notes:   Undriven data lines show the inverse of last cycle, never a held value
`timescale 1ns/1ps
module bbfh_flash_model #(
	parameter logic [15:0] MAKER_CODE = 16'h3c5a, // Arbitrary value
	parameter logic [15:0] PART_CODE  = 16'h7e81  // Arbitrary value
) (
	input  wire logic        ref_clk,
	input  wire logic        chip_sel_n,
	input  wire logic        out_en_n,
	input  wire logic        wr_strobe_n,
	input  wire logic        width_word,
	input  wire logic        reset_n,
	input  wire logic        boot_unlock_en,
	input  wire logic        program_supply_en,
	input  wire logic        identify_en,
	input  wire logic [17:0] address_inputs,
	input  wire logic [15:0] dq_out,
	input  wire logic [15:0] dq_oe_n,
	output logic      [15:0] dq_in,
	output int               clashes
);
	logic [15:0] mem [int];
	logic [15:0] val, flt = 16'h0000;
	logic [7:0]  cmd = 8'h00;
	logic        stat = 1'b0, armed = 1'b0, drv, lane;
	int          w;
	initial clashes = 0;
	function automatic logic [15:0] rd(int a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction
	function automatic int blk(int a);
		return a >= 'h3e000 ? 6 : a >= 'h3d000 ? 5 : a >= 'h3c000 ? 4 : a >= 'h30000 ? 3 : a >> 16;
	endfunction
	assign lane = !width_word && !dq_oe_n[15] && dq_out[15];
	always @(negedge reset_n) begin
		cmd = 8'h00;
		stat = 1'b0;
	end
	always @(negedge wr_strobe_n or negedge chip_sel_n) armed = !wr_strobe_n && !chip_sel_n;
	// Whichever of strobe or select rises first ends the cycle
	always @(posedge wr_strobe_n or posedge chip_sel_n) if (armed && reset_n) begin
		armed = 1'b0;
		w = address_inputs;
		if (!program_supply_en || !(cmd inside {8'h10, 8'h40, 8'h20})) begin
			cmd = dq_out[7:0];
			if (cmd == 8'hff) stat = 1'b0;
		end else if (blk(w) == 6 && !boot_unlock_en) begin
			cmd = 8'h00;
			stat = 1'b1;
		end else begin
			if (cmd == 8'h20 && dq_out[7:0] == 8'hd0) foreach (mem[k]) if (blk(k) == blk(w)) mem[k] = 16'hffff;
			if (cmd != 8'h20) mem[w] = rd(w) & (width_word ? dq_out : lane ? {dq_out[7:0], 8'hff} : {8'hff, dq_out[7:0]});
			cmd = 8'h00;
			stat = 1'b1;
		end
	end
	always @* begin
		drv = reset_n && !chip_sel_n && !out_en_n && wr_strobe_n;
		if (stat) val = 16'h0080;
		else if (identify_en && address_inputs[17:1] == 17'h0) val = address_inputs[0] ? PART_CODE : MAKER_CODE;
		else begin
			val = rd(address_inputs);
			if (lane) val[7:0] = val[15:8];
		end
		dq_in = drv ? (width_word ? val : {flt[15:8], val[7:0]}) : flt;
	end
	always @(posedge ref_clk) begin
		flt <= ~dq_in;
		if (drv && (dq_oe_n | {!width_word, 15'h0}) !== 16'hffff) clashes++;
	end
endmodule

/* File: sim/test_boot_block_flash_bus_port.sv */
// Purpose: Self-checking bench of the flash host controller
// Assumes: One request at a time, answered within a few hundred cycles
// Notes:   Reads through rdx go through read-array first to leave status mode
`timescale 1ns/1ps
module test_boot_block_flash_bus_port;
	import bbfh_pkg::*;
	localparam logic [15:0] MAKER = 16'h3c5a; // Arbitrary value
	localparam logic [15:0] PART  = 16'h7e81; // Arbitrary value
	logic ref_clk = 0, sys_rst = 1, req_valid = 0, req_byte = 0, req_boot = 0;
	bbfh_op_t req_op = BBFH_OP_READ;
	logic [18:0] req_addr = '0;
	logic [15:0] req_wdata = '0, rsp_rdata, dq_in, dq_out, dq_oe_n, got;
	logic req_ready, rsp_valid, chip_sel_n, out_en_n, wr_strobe_n, width_word, reset_n;
	logic boot_unlock_en, program_supply_en, identify_en;
	logic [17:0] address_inputs;
	int n_errors = 0, n_compared = 0, cycles = 0, clashes;
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %s", $time, m); end end
	bbfh_host bbfh_host_i (.ref_clk, .sys_rst, .req_valid, .req_op, .req_addr, .req_wdata,
		.req_byte, .req_boot, .req_ready, .rsp_valid, .rsp_rdata, .chip_sel_n, .out_en_n,
		.wr_strobe_n, .width_word, .reset_n, .boot_unlock_en, .program_supply_en,
		.identify_en, .address_inputs, .dq_in, .dq_out, .dq_oe_n);
	bbfh_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) bbfh_flash_model_i (.ref_clk,
		.chip_sel_n, .out_en_n, .wr_strobe_n, .width_word, .reset_n, .boot_unlock_en,
		.program_supply_en, .identify_en, .address_inputs, .dq_out, .dq_oe_n, .dq_in, .clashes);
	always #5 ref_clk = ~ref_clk;
	task automatic report_and_stop;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Hang guard: all scenarios need well under this many cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic op(bbfh_op_t o, logic [18:0] ad, logic [15:0] wd, logic by, logic bt);
		int k;
		@(posedge ref_clk);
		req_op <= o;
		req_addr <= ad;
		req_wdata <= wd;
		req_byte <= by;
		req_boot <= bt;
		req_valid <= 1'b1;
		k = 0;
		do begin @(negedge ref_clk); k++; end while (req_ready !== 1'b1 && k < 300);
		@(posedge ref_clk);
		req_valid <= 1'b0;
		k = 0;
		do begin @(negedge ref_clk); k++; end while (rsp_valid !== 1'b1 && k < 300);
		`CHK(rsp_valid, 1'b1, "no answer")
		got = rsp_rdata;
	endtask
	task automatic rdx(logic [18:0] ad, logic by);
		op(BBFH_OP_ARRAY, 0, 0, 0, 0);
		op(BBFH_OP_READ, ad, 0, by, 0);
	endtask
	task automatic t_word;
		op(BBFH_OP_WRITE, 19'h01234, 16'hbeef, 0, 0);
		op(BBFH_OP_READ, 19'h01234, 0, 0, 0);
		`CHK(got, 16'h0080, "status after write")
		rdx(19'h01234, 0);
		`CHK(got, 16'hbeef, "word data")
		rdx(19'h01235, 0);
		`CHK(got, 16'hffff, "neighbour word")
	endtask
	task automatic t_byte;
		op(BBFH_OP_WRITE, 19'h00011, 16'h00a5, 1, 0);
		rdx(19'h00011, 1);
		`CHK(got[7:0], 8'ha5, "odd byte")
		rdx(19'h00008, 0);
		`CHK(got, 16'ha5ff, "byte lane")
	endtask
	task automatic t_boot;
		op(BBFH_OP_WRITE, 19'h3f000, 16'h1111, 0, 0);
		rdx(19'h3f000, 0);
		`CHK(got, 16'hffff, "locked boot block")
		op(BBFH_OP_WRITE, 19'h3f000, 16'h1111, 0, 1);
		rdx(19'h3f000, 0);
		`CHK(got, 16'h1111, "unlocked boot block")
	endtask
	task automatic t_erase;
		op(BBFH_OP_WRITE, 19'h3c010, 16'h2222, 0, 0);
		op(BBFH_OP_WRITE, 19'h3d010, 16'h3333, 0, 0);
		op(BBFH_OP_ERASE, 19'h3c000, 0, 0, 0);
		rdx(19'h3c010, 0);
		`CHK(got, 16'hffff, "erased block")
		rdx(19'h3d010, 0);
		`CHK(got, 16'h3333, "other block kept")
	endtask
	task automatic t_ident;
		op(BBFH_OP_IDENT, 19'h00000, 0, 0, 0);
		`CHK(got, MAKER, "maker code")
		op(BBFH_OP_IDENT, 19'h00001, 0, 0, 0);
		`CHK(got, PART, "part code")
		op(BBFH_OP_IDENT, 19'h00001, 0, 1, 0);
		`CHK(got[7:0], PART[7:0], "byte part code")
	endtask
	task automatic t_reset;
		op(BBFH_OP_WRITE, 19'h00100, 16'h5a5a, 0, 0);
		op(BBFH_OP_RESET, 0, 0, 0, 0);
		op(BBFH_OP_READ, 19'h00100, 0, 0, 0);
		`CHK(got, 16'h5a5a, "array mode after pin reset")
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_word();
		t_byte();
		t_boot();
		t_erase();
		t_ident();
		t_reset();
		`CHK(clashes, 0, "data bus clash")
		report_and_stop();
	end
endmodule
